//--- bench/msd_ext_model.sv
// Partner model of the external devices on the expansion bus.
`timescale 1ns/1ps
`default_nettype none
module msd_ext_model (
    input  wire logic       clk_sys,
    input  wire logic       ext_bus_en_q,
    input  wire logic       ext_cycle_q,
    input  wire logic [7:0] port_b_addr_q,
    input  wire logic [7:0] port_f_addr_q,
    output var  int         stray_n,
    output var  int         seen_n
);
    // Counts bus cycles and flags any that arrive while the pins are I/O.
    initial stray_n = 0;
    initial seen_n = 0;
    always @(posedge clk_sys) begin
        if (ext_cycle_q === 1'b1) begin
            seen_n <= seen_n + 1;
            if (ext_bus_en_q !== 1'b1) stray_n <= stray_n + 1;
        end
    end
endmodule : msd_ext_model
`default_nettype wire

//--- bench/test_msd_decoder.sv
// Self-checking bench of the mode select and memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module test_msd_decoder;
    logic clk_sys = 0, nrst = 0, mode_input_a = 0, mode_input_b = 0, cpu_valid = 0;
    logic cpu_write = 0, cpu_vector = 0, eeprom_enable_cfg = 0, eeprom_enable_set = 0;
    logic boot_download_active = 0, ext_bus_en_q, ext_cycle_q, rw_q, port_c_data_dir_q;
    logic privileged_q, eeprom_on_q, txd_wired_or_q, pend = 0, eon;
    logic [3:0] ram_base_field = 0, reg_base_field = 1, eeprom_base_field = 0;
    logic [15:0] cpu_addr = 0, map_addr_q, last_ext = 0;
    logic [7:0] port_b_addr_q, port_f_addr_q;
    logic [20:0] n;
    logic [20:0] notes [$];
    logic [31:0] rnd = 32'h2AFE;
    msd_pkg::msd_mode_e mode_q;
    msd_pkg::msd_sel_e sel_q;
    int bad_count = 0, num_checks = 0, cyc = 0, stray_n, seen_n;

    msd_decoder uut (.clk_sys, .nrst, .mode_input_a, .mode_input_b, .ram_base_field,
        .reg_base_field, .eeprom_base_field, .eeprom_enable_cfg, .eeprom_enable_set,
        .cpu_addr, .cpu_valid, .cpu_write, .cpu_vector, .boot_download_active, .mode_q,
        .sel_q, .map_addr_q, .ext_bus_en_q, .ext_cycle_q, .port_b_addr_q, .port_f_addr_q,
        .rw_q, .port_c_data_dir_q, .privileged_q, .eeprom_on_q, .txd_wired_or_q);
    msd_ext_model ext (.clk_sys, .ext_bus_en_q, .ext_cycle_q, .port_b_addr_q,
        .port_f_addr_q, .stray_n, .seen_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling that cuts a hang short.
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs

    // Responder that the map should pick for one request.
    function automatic logic [2:0] ref_sel(input logic [1:0] m, input logic [15:0] a,
                                           input logic v);
        logic [3:0] ep;
        ep = m[1] ? eeprom_base_field : 4'hF;
        if (m == 2'h0 && v) a = {10'h2FF, a[5:0]};
        if (m == 2'h2 && v) return 3'h7;
        if (a[15:12] == reg_base_field && a[11:0] < 12'h060) return 3'h1;
        if (a[15:12] == ram_base_field && a[11:0] < 12'h400) return 3'h3;
        if (m == 2'h0 && a[15:8] == 8'hBF) return 3'h2;
        if (eon && a[15:12] == ep && a[11:9] == 3'h7) return 3'h6;
        if (m == 2'h2 && a[15:12] == eeprom_base_field && a[11:8] == 4'hD) return 3'h0;
        return m[1] ? 3'h7 : 3'h0;
    endfunction : ref_sel

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // Watcher takes the oldest note one cycle after each accepted request.
    always @(posedge clk_sys) pend <= cpu_valid;
    always @(negedge clk_sys) begin
        if (!nrst) last_ext = 16'h0000; // Reset clears the address pins.
        if (pend) begin
            n = notes.pop_front();
            check(sel_q, n[20:18]);
            check(ext_cycle_q, n[17]);
            if (n[17]) last_ext = n[16:1];
            check({port_b_addr_q, port_f_addr_q}, last_ext);
            if (n[17]) check({rw_q, port_c_data_dir_q}, {~n[0], n[0]});
        end
    end

    task automatic do_reset(input logic [1:0] m);
        @(negedge clk_sys);
        nrst = 0;
        {mode_input_b, mode_input_a} = m;
        repeat (8) @(negedge clk_sys);
        nrst = 1;
        repeat (3) @(negedge clk_sys);
        {mode_input_b, mode_input_a} = ~m; // Straps must be ignored from here on.
    endtask : do_reset

    // Back-to-back random requests aimed at every page of interest.
    task automatic burst(input logic [1:0] m);
        logic [3:0] pg [8];
        pg = '{ram_base_field, reg_base_field, eeprom_base_field, 4'hF, 4'hB, 4'hD, 4'h0,
               4'h1};
        repeat (40) begin
            @(negedge clk_sys);
            rnd = xs(rnd);
            cpu_addr = {pg[rnd[2:0]], rnd[3] ? {4'h0, rnd[15:8]} : rnd[27:16]};
            cpu_valid = rnd[31:30] != 2'h0;
            cpu_write = rnd[29];
            cpu_vector = rnd[28] & rnd[5];
            n[20:18] = ref_sel(m, cpu_addr, cpu_vector);
            if (cpu_valid) notes.push_back({n[20:18], n[20:18] == 3'h7, cpu_addr, cpu_write});
        end
        @(negedge clk_sys);
        cpu_valid = 0;
        repeat (2) @(negedge clk_sys);
    endtask : burst

    ////////////////////////////////////////////////////////////////////////////////
    // Each mode: defaults, then a shared page, then random placement.
    initial begin
        for (int m = 0; m < 4; m++) begin
            ram_base_field = 4'h0;
            reg_base_field = 4'h1;
            eeprom_enable_cfg = 1;
            do_reset(m[1:0]);
            boot_download_active = 1;
            repeat (2) @(negedge clk_sys);
            check(txd_wired_or_q, m == 0);
            boot_download_active = 0;
            check(mode_q, m[1:0]);
            check({ext_bus_en_q, privileged_q}, {m[1], m == 2});
            eon = m != 2;
            check(eeprom_on_q, eon);
            burst(m[1:0]);
            eeprom_enable_set = 1;
            @(negedge clk_sys);
            eeprom_enable_set = 0;
            eon = 1;
            reg_base_field = rnd[3:0];
            ram_base_field = rnd[3:0];
            eeprom_base_field = rnd[7:4];
            repeat (2) @(negedge clk_sys);
            burst(m[1:0]);
            ram_base_field = rnd[11:8];
            eeprom_enable_cfg = rnd[12];
            eon = m < 2 || rnd[12];
            repeat (2) @(negedge clk_sys);
            check(eeprom_on_q, eon);
            burst(m[1:0]);
            $display("Mode %0d test done", m);
        end
        check(stray_n[15:0], 16'h0);
        check(seen_n != 0, 1'b1);
        give_verdict();
    end
endmodule : test_msd_decoder
`default_nettype wire

//--- core/msd_decoder.sv
// Mode latch, on-chip memory map decoder and expansion bus pin steering.
//
// Summary of operation
// - Mode latched from two mode inputs at reset release; four modes.
// - Single-chip mode has no external bus; ports B, C, F stay general I/O.
// - Expanded mode drives high address on B, low on F, data on C, direction.
// - Test mode acts as expanded mode plus privileged internal access.
// - Boot ROM at BF00-BFFF only in bootstrap mode.
// - Bootstrap vectors fetched from boot ROM at BFC0 and up.
// - Boot firmware loads up to 1024 bytes, jumps to 0000 on gap or 03FF.
// - During boot download the transmit pin port is open-drain wired-OR.
// - Bootstrap interrupt vectors resolve to a RAM jump table.
// - Register block at page 1 after reset, movable by register-base field.
// - RAM at page 0 after reset, movable by RAM-base field.
// - Registers win over RAM on a shared page, hiding 96 RAM bytes.
// - Enabled EEPROM sits at FE00-FFFF by default.
// - Expanded and test modes move EEPROM to xE00 of the selected page.
// - Single-chip and bootstrap force EEPROM on at its default window.
// - EEPROM starts disabled on entry to test mode.
// - Test mode vectors go external; page zD00-zDFF runs externally only for vector fetches.
`timescale 1ns/1ps
`default_nettype none
`include "msd_defines.svh"

module msd_decoder (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              mode_input_a,
    input  wire logic              mode_input_b,
    input  wire logic [3:0]        ram_base_field,
    input  wire logic [3:0]        reg_base_field,
    input  wire logic [3:0]        eeprom_base_field,
    input  wire logic              eeprom_enable_cfg,
    input  wire logic              eeprom_enable_set,
    input  wire logic [15:0]       cpu_addr,
    input  wire logic              cpu_valid,
    input  wire logic              cpu_write,
    input  wire logic              cpu_vector,
    input  wire logic              boot_download_active,
    output var  msd_pkg::msd_mode_e mode_q,
    output var  msd_pkg::msd_sel_e  sel_q,
    output logic [15:0]            map_addr_q,
    output logic                   ext_bus_en_q,
    output logic                   ext_cycle_q,
    output logic [7:0]             port_b_addr_q,
    output logic [7:0]             port_f_addr_q,
    output logic                   rw_q,
    output logic                   port_c_data_dir_q,
    output logic                   privileged_q,
    output logic                   eeprom_on_q,
    output logic                   txd_wired_or_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release synchroniser.
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    // Two flip-flops release the reset on a clock edge.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode latch: single-chip during reset, sampled each cycle until the synchronised reset releases, frozen after.
    msd_pkg::msd_mode_e mode_d;
    logic               ee_test_dis_q;
    logic               ee_test_dis_d;

    // The mode inputs are followed from nrst release until rst_sync_q rises, and kept from then on.
    always_comb begin
        mode_d        = mode_q;
        ee_test_dis_d = ee_test_dis_q;
        if (!rst_sync_q) begin
            mode_d        = msd_pkg::msd_mode_e'({mode_input_b, mode_input_a});
            ee_test_dis_d = 1'b1;
        end else if (eeprom_enable_set) begin
            ee_test_dis_d = 1'b0;
        end
    end

    // The latch runs on the raw reset, so it reads single-chip until nrst releases and only then sees the inputs.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_q        <= msd_pkg::MSD_SINGLE;
            ee_test_dis_q <= 1'b1;
        end else begin
            mode_q        <= mode_d;
            ee_test_dis_q <= ee_test_dis_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.
    logic            is_exp_like;
    logic            is_boot;
    logic            ee_on;
    logic [3:0]      ee_page;
    logic [3:0]      pg;
    logic [11:0]     off;
    logic [15:0]     eff_addr;
    logic            hit_reg;
    logic            hit_ram;
    logic            hit_boot;
    logic            hit_ee;
    logic            test_hole;
    msd_pkg::msd_sel_e sel_d;

    assign is_exp_like = (mode_q == msd_pkg::MSD_EXP) || (mode_q == msd_pkg::MSD_TEST);
    assign is_boot     = (mode_q == msd_pkg::MSD_BOOT);

    // EEPROM placement: forced at the default page outside the bus modes.
    always_comb begin
        if (is_exp_like) begin
            ee_page = eeprom_base_field;
            ee_on   = eeprom_enable_cfg && !((mode_q == msd_pkg::MSD_TEST) && ee_test_dis_q);
        end else begin
            ee_page = `MSD_EE_DEFAULT_PAGE;
            ee_on   = 1'b1;
        end
    end

    // Bootstrap vectors above BFC0 are served by the RAM jump table pointers in ROM.
    always_comb begin
        eff_addr = cpu_addr;
        if (is_boot && cpu_vector) begin
            eff_addr = {`MSD_BOOT_HI_BYTE, `MSD_VEC_LO_MIN | cpu_addr[7:0]};
        end
    end

    assign pg        = eff_addr[15:12];
    assign off       = eff_addr[11:0];
    assign hit_reg   = (pg == reg_base_field) && (off < `MSD_REG_SIZE);
    assign hit_ram   = (pg == ram_base_field) && (off < `MSD_RAM_SIZE);
    assign hit_boot  = is_boot && (eff_addr[15:8] == `MSD_BOOT_HI_BYTE);
    assign hit_ee    = ee_on && (pg == ee_page) && (off >= `MSD_EE_LO_OFF);
    assign test_hole = (mode_q == msd_pkg::MSD_TEST)
                       && (pg == eeprom_base_field) && (off[11:8] == `MSD_TEST_HOLE_HI);

    // Fixed priority gives each address at most one responder.
    always_comb begin
        sel_d = msd_pkg::MSD_SEL_NONE;
        if (!cpu_valid) begin
            sel_d = msd_pkg::MSD_SEL_NONE;
        end else if ((mode_q == msd_pkg::MSD_TEST) && cpu_vector) begin
            sel_d = msd_pkg::MSD_SEL_EXT;
        end else if (hit_reg) begin
            sel_d = msd_pkg::MSD_SEL_REG;
        end else if (hit_ram) begin
            sel_d = msd_pkg::MSD_SEL_RAM;
        end else if (hit_boot) begin
            sel_d = msd_pkg::MSD_SEL_BOOT;
        end else if (hit_ee) begin
            sel_d = msd_pkg::MSD_SEL_EE;
        end else if (is_exp_like && !test_hole) begin
            sel_d = msd_pkg::MSD_SEL_EXT;
        end else begin
            sel_d = msd_pkg::MSD_SEL_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs and bus pin steering.
    logic        ext_d;
    logic [7:0]  pb_d;
    logic [7:0]  pf_d;

    assign ext_d = (sel_d == msd_pkg::MSD_SEL_EXT);
    // Address pins take each external address and hold it until the next one.
    assign pb_d  = ext_d ? eff_addr[15:8] : port_b_addr_q;
    assign pf_d  = ext_d ? eff_addr[7:0]  : port_f_addr_q;

    // All outputs but mode_q come from flip-flops reset by the synchronised reset.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_q             <= msd_pkg::MSD_SEL_NONE;
            map_addr_q        <= 16'h0000;
            ext_bus_en_q      <= 1'b0;
            ext_cycle_q       <= 1'b0;
            port_b_addr_q     <= 8'h00;
            port_f_addr_q     <= 8'h00;
            rw_q              <= 1'b1;
            port_c_data_dir_q <= 1'b0;
            privileged_q      <= 1'b0;
            eeprom_on_q       <= 1'b0;
            txd_wired_or_q    <= 1'b0;
        end else begin
            sel_q             <= sel_d;
            map_addr_q        <= eff_addr;
            ext_bus_en_q      <= is_exp_like;
            ext_cycle_q       <= ext_d;
            port_b_addr_q     <= pb_d;
            port_f_addr_q     <= pf_d;
            rw_q              <= !(ext_d && cpu_write);
            port_c_data_dir_q <= ext_d && cpu_write;
            privileged_q      <= (mode_q == msd_pkg::MSD_TEST);
            eeprom_on_q       <= ee_on;
            txd_wired_or_q    <= is_boot && boot_download_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.
    a_mode_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $stable(mode_q)) else $error("mode changed after reset");
    a_single_no_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == msd_pkg::MSD_SINGLE) |=> !ext_cycle_q && !ext_bus_en_q)
        else $error("external cycle in single-chip mode");
    a_ext_addr_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ext_d |=> {port_b_addr_q, port_f_addr_q} == $past(eff_addr))
        else $error("address pins wrong");
    a_boot_rom_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sel_q == msd_pkg::MSD_SEL_BOOT) |-> $past(is_boot) && map_addr_q[15:8] == 8'hBF)
        else $error("boot ROM outside bootstrap");
    a_reg_wins_ram: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpu_valid && hit_reg && !cpu_vector) |=> sel_q == msd_pkg::MSD_SEL_REG)
        else $error("register block lost priority");
    a_ee_forced_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !is_exp_like |=> eeprom_on_q) else $error("EEPROM not forced on");
    a_test_hole_int: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpu_valid && test_hole && !cpu_vector) |=> !ext_cycle_q)
        else $error("test hole driven externally");
    a_test_vec_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == msd_pkg::MSD_TEST && cpu_valid && cpu_vector) |=> ext_cycle_q)
        else $error("test vector not external");
    a_boot_no_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_boot |=> !ext_cycle_q) else $error("external cycle in bootstrap");
    a_txd_wired_or: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_boot && boot_download_active) |=> txd_wired_or_q)
        else $error("transmit port not wired-OR");

    ////////////////////////////////////////////////////////////////////////////////
    // Further checks on the decode, one per rule that the map must keep.

    // The expansion bus pins are handed to the bus in both bus modes.
    a_exp_bus_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_exp_like |=> ext_bus_en_q)
        else $error("expansion bus not enabled");

    // Test mode always reports its privileged access.
    a_test_priv: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == msd_pkg::MSD_TEST) |=> privileged_q)
        else $error("test mode not privileged");

    // Bootstrap vector fetches land in the top quarter of the boot ROM page.
    a_boot_vec_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_boot && cpu_vector) |=> map_addr_q[15:6] == 10'h2FF)
        else $error("boot vector outside vector area");

    // An unclaimed access to the boot page in bootstrap mode reaches the ROM.
    a_boot_rom_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpu_valid && is_boot && !hit_reg && !hit_ram && eff_addr[15:8] == 8'hBF)
        |=> sel_q == msd_pkg::MSD_SEL_BOOT)
        else $error("boot ROM not selected");

    // RAM answers on its own page wherever the registers do not.
    a_ram_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpu_valid && !cpu_vector && hit_ram && !hit_reg)
        |=> sel_q == msd_pkg::MSD_SEL_RAM)
        else $error("RAM not selected");

    // An enabled EEPROM window answers when nothing of higher priority does.
    a_ee_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpu_valid && !cpu_vector && hit_ee && !hit_reg && !hit_ram && !hit_boot)
        |=> sel_q == msd_pkg::MSD_SEL_EE)
        else $error("EEPROM window not selected");

    // The EEPROM stays off in test mode until it is enabled.
    a_ee_test_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((mode_q == msd_pkg::MSD_TEST) && ee_test_dis_q) |=> !eeprom_on_q)
        else $error("EEPROM on at test mode entry");

    // Outside the bus modes the EEPROM only ever hits on the top page.
    a_ee_page_fixed: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!is_exp_like && hit_ee) |-> pg == 4'hF)
        else $error("EEPROM moved in a fixed mode");

    // Unclaimed addresses in the bus modes, outside the test hole, run as external cycles.
    a_exp_ext_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpu_valid && is_exp_like && !test_hole && !cpu_vector && !hit_reg && !hit_ram
         && !hit_ee) |=> ext_cycle_q)
        else $error("unclaimed address not external");

    // An external write turns the data port around and drives the line low.
    a_write_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ext_d && cpu_write) |=> !rw_q && port_c_data_dir_q)
        else $error("external write direction wrong");

    c_boot_rom: cover property (@(posedge clk_sys) disable iff (!rst_n)
        sel_q == msd_pkg::MSD_SEL_BOOT);
    c_ext_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
        ext_cycle_q && !rw_q);
    c_ee_remap: cover property (@(posedge clk_sys) disable iff (!rst_n)
        sel_q == msd_pkg::MSD_SEL_EE && map_addr_q[15:12] != 4'hF);
    c_ram_hidden: cover property (@(posedge clk_sys) disable iff (!rst_n)
        cpu_valid && hit_reg && hit_ram);
    // A vector fetch taken out to the bus in test mode.
    c_test_vector: cover property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == msd_pkg::MSD_TEST) && cpu_valid && cpu_vector);

endmodule : msd_decoder

`default_nettype wire

//--- shared/msd_defines.svh
// Address map constants and field layouts of the mode select and memory map decoder.
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH

`define MSD_REG_RESET_PAGE  4'h1
`define MSD_RAM_RESET_PAGE  4'h0
`define MSD_EE_DEFAULT_PAGE 4'hF
`define MSD_REG_SIZE        12'h060
`define MSD_RAM_SIZE        12'h400
`define MSD_EE_LO_OFF       12'hE00
`define MSD_TEST_HOLE_HI    4'hD
`define MSD_BOOT_HI_BYTE    8'hBF
`define MSD_VEC_LO_MIN      8'hC0
`define MSD_BOOT_LAST_ADDR  16'h03FF
`define MSD_BOOT_ENTRY_ADDR 16'h0000
`define MSD_BOOT_MAX_BYTES  11'h400

`endif

//--- shared/msd_pkg.sv
// Types shared by the mode select and memory map decoder.
package msd_pkg;
    // Operating modes; the code is the pair {mode_input_b, mode_input_a}.
    typedef enum logic [1:0] {
        MSD_BOOT   = 2'h0,
        MSD_SINGLE = 2'h1,
        MSD_TEST   = 2'h2,
        MSD_EXP    = 2'h3
    } msd_mode_e;

    // Responder selected for a decoded address.
    typedef enum logic [2:0] {
        MSD_SEL_NONE = 3'h0,
        MSD_SEL_REG  = 3'h1,
        MSD_SEL_RAM  = 3'h3,
        MSD_SEL_BOOT = 3'h2,
        MSD_SEL_EE   = 3'h6,
        MSD_SEL_EXT  = 3'h7
    } msd_sel_e;
endpackage : msd_pkg
